/* design/reset_source_control.sv */
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
// Purpose: Reset source control with keyed commit and cause flags.
// Assumes: rst_in is the power-on reset; other sources are level inputs.
// Notes:   Sources are synchronous to core_clk_in.

module reset_source_control
	import reset_source_pkg::*;
(
	input  wire logic                          core_clk_in,   // Clock
	input  wire logic                          rst_in,        // Power-on
	input  wire logic                          ext_reset_in,  // Pin, high
	input  wire logic                          vdet1_in,      // Voltage 1
	input  wire logic                          vdet2_in,      // Voltage 2
	input  wire logic                          watchdog_in,   // Watchdog
	input  wire logic                          clk_fault_in,  // Clock fault
	input  wire logic                          trim_fault_in, // Trim reset
	input  wire logic                          trim_abn_in,   // Trim status
	input  wire logic                          flash_sb_in,   // Flash standby
	input  wire logic [reset_source_pkg::ADDR_W-1:0] addr_in, // Address
	input  wire logic [reset_source_pkg::DATA_W-1:0] wdata_in, // Write data
	input  wire logic                          wr_in,         // Write strobe
	input  wire logic                          rd_in,         // Read strobe
	output logic      [reset_source_pkg::DATA_W-1:0] rdata_out, // Read data
	output logic                               sys_reset_out, // System reset
	output logic                               cpu_run_out,   // Run enable
	output logic                               vector_sel_out, // Committed b2
	output logic                               area_sel_out,  // Committed b1
	output logic                               irq_out        // Interrupt
);
	import reset_source_pkg::*;

	reset_event_if ev ();

	// ------------------------------------------------------------
	// Reset combining
	// ------------------------------------------------------------
	logic                  ext_reset_disable_committed;
	logic                  reset_vector_committed;
	logic                  reset_area_committed;
	logic                  ext_gated;
	logic [NUM_CAUSES-1:0] causes;
	logic                  internal_any;
	logic                  any_reset;

	assign ext_gated = ext_reset_in && !ext_reset_disable_committed;
	assign causes = {flash_sb_in, trim_abn_in, trim_fault_in, vdet2_in,
		vdet1_in, clk_fault_in, watchdog_in};
	assign internal_any = |causes;
	assign any_reset = rst_in || ext_gated || internal_any;

	assign ev.por       = rst_in;
	assign ev.ext_reset = ext_gated;
	assign ev.any_reset = any_reset;
	assign ev.causes    = causes;

	// ------------------------------------------------------------
	// Sub-blocks
	// ------------------------------------------------------------
	logic [NUM_CAUSES-1:0] flags;
	logic                  flag_clear;
	logic                  warm_done;

	cause_flag_bank u_flags (
		.core_clk_in (core_clk_in),
		.ev          (ev.dst),
		.clear_in    (flag_clear),
		.flags_out   (flags)
	);

	warmup_sequencer u_warm (
		.core_clk_in (core_clk_in),
		.ev          (ev.dst),
		.run_out     (warm_done)
	);

	// ------------------------------------------------------------
	// Register writes and key commits
	// ------------------------------------------------------------
	logic       cfg_disable;
	logic       cfg_area;
	logic       cfg_vector;
	logic       clear_req;
	logic       next_cfg_disable;
	logic       next_cfg_area;
	logic       next_cfg_vector;
	logic       next_clear_req;
	logic       next_dis_commit;
	logic       next_area_commit;
	logic       next_vec_commit;
	logic       next_flag_clear;
	logic       key_wr;
	logic [NUM_CAUSES-1:0] irq_mask;
	logic [NUM_CAUSES-1:0] next_irq_mask;

	assign key_wr = wr_in && (addr_in == ADDR_KEY_STATUS);

	always_comb begin
		next_cfg_disable = cfg_disable;
		next_cfg_area    = cfg_area;
		next_cfg_vector  = cfg_vector;
		next_clear_req   = clear_req;
		next_dis_commit  = ext_reset_disable_committed;
		next_area_commit = reset_area_committed;
		next_vec_commit  = reset_vector_committed;
		next_flag_clear  = 1'b0;
		next_irq_mask    = irq_mask;
		if (wr_in && addr_in == ADDR_CONFIG) begin
			next_cfg_disable = wdata_in[BIT_DISABLE];
			next_cfg_area    = wdata_in[BIT_AREA];
			next_cfg_vector  = wdata_in[BIT_VECTOR];
		end
		if (wr_in && addr_in == ADDR_CAUSE_FLAGS) begin
			next_clear_req = wdata_in[BIT_CLEAR];
		end
		if (wr_in && addr_in == ADDR_IRQ_MASK) begin
			next_irq_mask = wdata_in[NUM_CAUSES-1:0];
		end
		if (key_wr) begin
			case (wdata_in)
				KEY_DISABLE: begin
					next_dis_commit = cfg_disable;
				end
				KEY_VECTOR: begin
					next_area_commit = cfg_area;
					next_vec_commit  = cfg_vector;
				end
				KEY_CLEAR: begin
					if (clear_req) begin
						next_flag_clear = 1'b1;
						next_clear_req  = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		if (any_reset) begin
			next_cfg_disable = 1'b0;
			next_cfg_area    = 1'b0;
			next_cfg_vector  = 1'b0;
			next_clear_req   = 1'b0;
			next_flag_clear  = 1'b0;
		end
		if (rst_in) begin
			next_dis_commit  = 1'b0;
			next_area_commit = 1'b0;
			next_vec_commit  = 1'b0;
			next_irq_mask    = FLAGS_RESET;
		end
	end

	always_ff @(posedge core_clk_in) begin
		cfg_disable                 <= next_cfg_disable;
		cfg_area                    <= next_cfg_area;
		cfg_vector                  <= next_cfg_vector;
		clear_req                   <= next_clear_req;
		ext_reset_disable_committed <= next_dis_commit;
		reset_area_committed        <= next_area_commit;
		reset_vector_committed      <= next_vec_commit;
		flag_clear                  <= next_flag_clear;
		irq_mask                    <= next_irq_mask;
	end

	// ------------------------------------------------------------
	// Interrupt status: sticky copy of cause events, cleared on read
	// ------------------------------------------------------------
	logic [NUM_CAUSES-1:0] irq_status;
	logic [NUM_CAUSES-1:0] next_irq_status;
	logic                  next_irq;

	always_comb begin
		next_irq_status = irq_status;
		if (rd_in && addr_in == ADDR_IRQ_STATUS) begin
			next_irq_status = FLAGS_RESET;
		end
		next_irq_status = next_irq_status | causes;
		if (rst_in) begin
			next_irq_status = FLAGS_RESET;
		end
		next_irq = |(next_irq_status & next_irq_mask);
	end

	always_ff @(posedge core_clk_in) begin
		irq_status <= next_irq_status;
		irq_out    <= next_irq;
	end

	// ------------------------------------------------------------
	// Read data and outputs
	// ------------------------------------------------------------
	logic [DATA_W-1:0] next_rdata;

	always_comb begin
		next_rdata = ZERO_BYTE;
		if (rd_in) begin
			case (addr_in)
				ADDR_CAUSE_FLAGS: begin
					next_rdata = {1'b0, flags};
				end
				ADDR_CONFIG: begin
					next_rdata = {5'h00, cfg_vector, cfg_area,
						cfg_disable};
				end
				ADDR_KEY_STATUS: begin
					next_rdata = {5'h00, reset_vector_committed,
						reset_area_committed,
						ext_reset_disable_committed};
				end
				ADDR_IRQ_STATUS: begin
					next_rdata = {1'b0, irq_status};
				end
				ADDR_IRQ_MASK: begin
					next_rdata = {1'b0, irq_mask};
				end
				default: begin
					next_rdata = ZERO_BYTE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		rdata_out      <= next_rdata;
		sys_reset_out  <= any_reset;
		cpu_run_out    <= warm_done && !any_reset;
		vector_sel_out <= next_vec_commit;
		area_sel_out   <= next_area_commit;
	end
endmodule

/* common/reset_source_pkg.sv */
// Purpose: Constants and types shared by the reset source control block.
// Assumes: 8-bit register port, one 250 MHz clock.
// Notes:   Register offsets are the byte addresses of the register port.
//
// Contract
// - Power-on reset, the pin and seven internal causes combine into system reset.
// - Committed configuration bit 0 at 1 ignores the external reset pin.
// - Only power-on reset returns the committed pin-disable value to default.
// - Every reset type clears the written configuration contents.
// - A written pin-disable value takes effect only after key 0xB2.
// - Key 0xB2, 0xD4, 0x71 commit their fields; other values ignored.
// - Key address read returns status; bit 0 is the committed disable.
// - Configuration bits 7 to 3 read as zero.
// - Cause register holds one flag per internal cause, bits 0 to 6.
// - Cause flags survive internal resets; cleared by power-on, pin, software.
// - Clear request then key 0x71 zeroes flags and drops the request.
// - Cause register bit 7 is write-only and reads as zero.
// - All resets feed warm-up; execution starts after warm-up ends.
// - A reset during warm-up restarts the warm-up counter.

package reset_source_pkg;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned NUM_CAUSES = 7;

	localparam logic [ADDR_W-1:0] ADDR_CAUSE_FLAGS = 12'hFCC;
	localparam logic [ADDR_W-1:0] ADDR_CONFIG      = 12'hFDE;
	localparam logic [ADDR_W-1:0] ADDR_KEY_STATUS  = 12'hFDF;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS  = 12'hFE0;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK    = 12'hFE1;

	localparam logic [DATA_W-1:0] KEY_DISABLE = 8'hB2;
	localparam logic [DATA_W-1:0] KEY_VECTOR  = 8'hD4;
	localparam logic [DATA_W-1:0] KEY_CLEAR   = 8'h71;

	localparam int unsigned BIT_DISABLE = 0;
	localparam int unsigned BIT_AREA    = 1;
	localparam int unsigned BIT_VECTOR  = 2;
	localparam int unsigned BIT_CLEAR   = 7;

	localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;
	localparam logic [2:0]        CFG_RESET  = 3'h0;
	localparam logic [NUM_CAUSES-1:0] FLAGS_RESET = 7'h00;

	// Warm-up length after reset release, in high-frequency clock cycles
	localparam int unsigned WARMUP_NS     = 1000;
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned WARMUP_CYCLES =
		(WARMUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WARM_W = 12;
	localparam logic [WARM_W-1:0] WARM_LAST = WARM_W'(WARMUP_CYCLES - 1);
	localparam logic [WARM_W-1:0] WARM_ZERO = 12'h000;

	typedef enum logic [1:0] {
		WARM_RESET = 2'b01,
		WARM_RUN   = 2'b10
	} warm_state_t;

endpackage

/* common/reset_event_if.sv */
`timescale 1ns/1ns
// Purpose: Carries reset events from the top to the cause and warm-up logic.
// Assumes: One clock domain.
// Notes:   Level signals, sampled each cycle.

interface reset_event_if;
	import reset_source_pkg::*;

	logic                  por;
	logic                  ext_reset;
	logic                  any_reset;
	logic [NUM_CAUSES-1:0] causes;

	modport src (
		output por,
		output ext_reset,
		output any_reset,
		output causes
	);
	modport dst (
		input por,
		input ext_reset,
		input any_reset,
		input causes
	);
endinterface

/* design/cause_flag_bank.sv */
`timescale 1ns/1ns
// Purpose: Sticky flags recording which internal source caused a reset.
// Assumes: Clear pulse comes from the key logic.
// Notes:   A source event wins over a clear in the same cycle.

module cause_flag_bank
	import reset_source_pkg::*;
(
	input  wire logic                  core_clk_in, // System clock
	reset_event_if.dst                 ev,          // Reset events
	input  wire logic                  clear_in,    // Software clear pulse
	output logic      [NUM_CAUSES-1:0] flags_out    // Sticky cause flags
);
	import reset_source_pkg::*;

	logic [NUM_CAUSES-1:0] flags;
	logic [NUM_CAUSES-1:0] next_flags;

	always_comb begin
		next_flags = flags;
		if (ev.por || ev.ext_reset || clear_in) begin
			next_flags = FLAGS_RESET;
		end
		next_flags = next_flags | ev.causes;
	end

	always_ff @(posedge core_clk_in) begin
		flags <= next_flags;
	end

	assign flags_out = flags;
endmodule

/* design/warmup_sequencer.sv */
`timescale 1ns/1ns
// Purpose: Holds the core in reset until warm-up after release finishes.
// Assumes: Any reset level restarts the count.
// Notes:   run_out high means program execution may start.

module warmup_sequencer
	import reset_source_pkg::*;
(
	input  wire logic core_clk_in, // System clock
	reset_event_if.dst ev,         // Reset events
	output logic      run_out      // Warm-up done
);
	import reset_source_pkg::*;

	warm_state_t       state;
	warm_state_t       next_state;
	logic [WARM_W-1:0] count;
	logic [WARM_W-1:0] next_count;

	always_comb begin
		next_state = state;
		next_count = count;
		case (state)
			WARM_RESET: begin
				if (ev.any_reset) begin
					next_count = WARM_ZERO;
				end else if (count == WARM_LAST) begin
					next_state = WARM_RUN;
				end else begin
					next_count = count + 12'h001;
				end
			end
			WARM_RUN: begin
				next_count = WARM_ZERO;
			end
			default: begin
				next_state = WARM_RESET;
				next_count = WARM_ZERO;
			end
		endcase
		if (ev.any_reset) begin
			next_state = WARM_RESET;
			next_count = WARM_ZERO;
		end
	end

	always_ff @(posedge core_clk_in) begin
		state <= next_state;
		count <= next_count;
	end

	assign run_out = (state == WARM_RUN);
endmodule

/* verif/reset_source_control_checker.sv */
// Purpose: Port-level assertions for reset source control.
// Assumes: One clock; rst_in is the synchronous power-on reset.
// Notes:   Attached by the bind at the foot.
`timescale 1ns/1ns
module reset_source_control_checker
	import reset_source_pkg::*;
(
	input wire logic              core_clk_in,    // Clock
	input wire logic              rst_in,         // Power-on
	input wire logic              ext_reset_in,   // Pin
	input wire logic              vdet1_in,       // Cause
	input wire logic              vdet2_in,       // Cause
	input wire logic              watchdog_in,    // Cause
	input wire logic              clk_fault_in,   // Cause
	input wire logic              trim_fault_in,  // Cause
	input wire logic              trim_abn_in,    // Cause
	input wire logic              flash_sb_in,    // Cause
	input wire logic [ADDR_W-1:0] addr_in,        // Address
	input wire logic [DATA_W-1:0] wdata_in,       // Write data
	input wire logic              wr_in,          // Write
	input wire logic              rd_in,          // Read
	input wire logic [DATA_W-1:0] rdata_out,      // Read data
	input wire logic              sys_reset_out,  // Reset
	input wire logic              cpu_run_out,    // Run
	input wire logic              vector_sel_out, // Bit 2
	input wire logic              area_sel_out,   // Bit 1
	input wire logic              irq_out         // Interrupt
);
	// ---
	// Helpers
	// ---
	logic [6:0]        causes;
	logic              key_d4;
	logic [WARM_W-1:0] quiet;
	logic [WARM_W-1:0] next_quiet;
	assign causes = {flash_sb_in, trim_abn_in, trim_fault_in, vdet2_in,
		vdet1_in, clk_fault_in, watchdog_in};
	assign key_d4 = wr_in && addr_in == ADDR_KEY_STATUS
		&& wdata_in == KEY_VECTOR;
	// Cycles since system reset last dropped
	always_comb begin
		next_quiet = quiet;
		if (rst_in || sys_reset_out)
			next_quiet = WARM_ZERO;
		else if (quiet != '1)
			next_quiet = quiet + 12'h001;
	end
	always_ff @(posedge core_clk_in) begin
		quiet <= next_quiet;
	end
	// ---
	// Assertions
	// ---
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	a_cause_resets: assert property (
		|causes |=> sys_reset_out) else $error("cause gave no reset");
	a_quiet_no_reset: assert property (
		!ext_reset_in && causes == 7'h00 |=> !sys_reset_out)
		else $error("reset without source");
	a_rdata_idle: assert property (
		!rd_in |=> rdata_out == ZERO_BYTE) else $error("stray read data");
	a_cfg_reserved: assert property (
		rd_in && addr_in == ADDR_CONFIG |=> rdata_out[7:3] == 5'h00)
		else $error("config reserved bits set");
	a_status_reserved: assert property (
		rd_in && addr_in == ADDR_KEY_STATUS |=> rdata_out[7:3] == 5'h00)
		else $error("status reserved bits set");
	a_clear_reads_zero: assert property (
		rd_in && addr_in == ADDR_CAUSE_FLAGS |=> !rdata_out[7])
		else $error("clear request read back");
	a_reset_stops_run: assert property (
		sys_reset_out |=> !cpu_run_out) else $error("run during reset");
	a_run_after_warm: assert property (
		$rose(cpu_run_out) |-> quiet >= WARMUP_CYCLES - 8)
		else $error("run before warm-up end");
	a_commit_hold: assert property (
		!$past(rst_in) && !$past(key_d4) |->
		$stable({vector_sel_out, area_sel_out}))
		else $error("committed bits moved");
	cover property (|causes ##2 sys_reset_out);
	cover property ($rose(cpu_run_out));
	cover property (key_d4 ##1 vector_sel_out);
	cover property ($fell(irq_out));
endmodule

bind reset_source_control reset_source_control_checker chk_u (
	.core_clk_in(core_clk_in), .rst_in(rst_in),
	.ext_reset_in(ext_reset_in), .vdet1_in(vdet1_in),
	.vdet2_in(vdet2_in), .watchdog_in(watchdog_in),
	.clk_fault_in(clk_fault_in), .trim_fault_in(trim_fault_in),
	.trim_abn_in(trim_abn_in), .flash_sb_in(flash_sb_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
	.rd_in(rd_in), .rdata_out(rdata_out),
	.sys_reset_out(sys_reset_out), .cpu_run_out(cpu_run_out),
	.vector_sel_out(vector_sel_out), .area_sel_out(area_sel_out),
	.irq_out(irq_out));

/* verif/reset_gen_model.sv */
// Purpose: Internal reset generators and the reset pin.
// Assumes: Request bit i fires cause i; bit 7 drives the pin.
// Notes:   Each request holds its line for two cycles.
`timescale 1ns/1ns
module reset_gen_model (
	input  wire logic       core_clk_in, // Clock
	input  wire logic [7:0] req_in,      // One-cycle request
	output logic      [6:0] causes_out,  // Cause levels
	output logic            pin_out      // Pin level
);
	logic [7:0] stage1;
	logic [7:0] stage2;
	always_ff @(posedge core_clk_in) begin
		stage1 <= req_in;
		stage2 <= stage1;
	end
	assign {pin_out, causes_out} = stage1 | stage2;
endmodule

/* verif/tb_reset_source_control.sv */
// Purpose: Self-checking bench for reset source control.
// Assumes: The model drives every reset source except rst_in, which the bench drives directly.
// Notes:   Table rows first, then reset sequences.
`timescale 1ns/1ns
module tb_reset_source_control;
	import reset_source_pkg::*;
	typedef struct packed {
		logic [11:0] wa;
		logic [7:0]  wd;
		logic [11:0] ra;
		logic [7:0]  ex;
	} row_t;
	logic        core_clk_in, rst_in, wr_in, rd_in, pin, sys_reset_out;
	logic        cpu_run_out, vsel, asel, irq_out;
	logic [11:0] addr_in;
	logic [7:0]  wdata_in, rdata_out, req;
	logic [6:0]  causes;
	int          fail_count, compares;
	row_t        rows [7];

	reset_gen_model gen_u (.core_clk_in(core_clk_in), .req_in(req),
		.causes_out(causes), .pin_out(pin));
	reset_source_control dut_u (.core_clk_in(core_clk_in),
		.rst_in(rst_in), .ext_reset_in(pin), .vdet1_in(causes[2]),
		.vdet2_in(causes[3]), .watchdog_in(causes[0]),
		.clk_fault_in(causes[1]), .trim_fault_in(causes[4]),
		.trim_abn_in(causes[5]), .flash_sb_in(causes[6]),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out),
		.sys_reset_out(sys_reset_out), .cpu_run_out(cpu_run_out),
		.vector_sel_out(vsel), .area_sel_out(asel), .irq_out(irq_out));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Key register is only ever written whole
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge core_clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge core_clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge core_clk_in);
		rd_in <= 1'b0;
		#1 chk(rdata_out, e);
	endtask
	task automatic pulse(input logic [7:0] m, input logic e);
		@(posedge core_clk_in);
		req <= m;
		@(posedge core_clk_in);
		req <= 8'h00;
		@(posedge core_clk_in);
		#1 chk({7'h00, sys_reset_out}, {7'h00, e});
		repeat (4) @(posedge core_clk_in);
	endtask
	task automatic close_out;
		if (fail_count == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end
	initial begin
		#200000;
		fail_count++;
		close_out();
	end
	// ---
	// Stimulus and checks
	// ---
	initial begin
		rst_in = 1'b1; wr_in = 1'b0; rd_in = 1'b0; req = 8'h00;
		addr_in = 12'h000; wdata_in = 8'h00;
		fail_count = 0; compares = 0;
		rows = '{'{ADDR_CONFIG, 8'hFF, ADDR_CONFIG, 8'h07},
			'{ADDR_KEY_STATUS, 8'h55, ADDR_KEY_STATUS, 8'h00},
			'{ADDR_KEY_STATUS, KEY_DISABLE, ADDR_KEY_STATUS, 8'h01},
			'{ADDR_KEY_STATUS, KEY_VECTOR, ADDR_KEY_STATUS, 8'h07},
			'{ADDR_CAUSE_FLAGS, 8'hFF, ADDR_CAUSE_FLAGS, 8'h00},
			'{ADDR_IRQ_MASK, 8'h7F, ADDR_IRQ_MASK, 8'h7F},
			'{12'h123, 8'hAA, 12'h123, 8'h00}};
		repeat (3) @(posedge core_clk_in);
		rst_in <= 1'b0;
		for (int k = 0; k < 300 && cpu_run_out !== 1'b1; k++)
			@(posedge core_clk_in);
		chk({7'h00, cpu_run_out}, 8'h01);
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd);
			rd(rows[i].ra, rows[i].ex);
		end
		chk({6'h00, vsel, asel}, 8'h03);
		pulse(8'h80, 1'b0);
		for (int i = 0; i < 7; i++) begin
			pulse(8'h01 << i, 1'b1);
			rd(ADDR_CAUSE_FLAGS, (8'h02 << i) - 8'h01);
		end
		rd(ADDR_KEY_STATUS, 8'h07);
		rd(ADDR_CONFIG, 8'h00);
		chk({7'h00, irq_out}, 8'h01);
		rd(ADDR_IRQ_STATUS, 8'h7F);
		chk({7'h00, irq_out}, 8'h00);
		wr(ADDR_KEY_STATUS, KEY_CLEAR);
		rd(ADDR_CAUSE_FLAGS, 8'h7F);
		@(posedge core_clk_in);
		wr_in <= 1'b1;
		addr_in <= ADDR_CAUSE_FLAGS;
		wdata_in <= 8'h80;
		@(posedge core_clk_in);
		addr_in <= ADDR_KEY_STATUS;
		wdata_in <= KEY_CLEAR;
		@(posedge core_clk_in);
		wr_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		rd(ADDR_CAUSE_FLAGS, 8'h00);
		pulse(8'h01, 1'b1);
		wr(ADDR_KEY_STATUS, KEY_CLEAR);
		rd(ADDR_CAUSE_FLAGS, 8'h01);
		wr(ADDR_CONFIG, 8'h00);
		wr(ADDR_KEY_STATUS, KEY_DISABLE);
		rd(ADDR_KEY_STATUS, 8'h06);
		pulse(8'h80, 1'b1);
		rd(ADDR_CAUSE_FLAGS, 8'h00);
		rd(ADDR_KEY_STATUS, 8'h06);
		@(posedge core_clk_in);
		rst_in <= 1'b1;
		repeat (3) @(posedge core_clk_in);
		rst_in <= 1'b0;
		rd(ADDR_KEY_STATUS, 8'h00);
		chk({6'h00, vsel, asel}, 8'h00);
		// Internal reset in mid warm-up must restart the count
		repeat (100) @(posedge core_clk_in);
		pulse(8'h01, 1'b1);
		rd(ADDR_IRQ_MASK, 8'h00);
		chk({7'h00, irq_out}, 8'h00);
		repeat (WARMUP_CYCLES - 8) @(posedge core_clk_in);
		#1 chk({7'h00, cpu_run_out}, 8'h00);
		for (int k = 0; k < 20 && cpu_run_out !== 1'b1; k++)
			@(posedge core_clk_in);
		chk({7'h00, cpu_run_out}, 8'h01);
		close_out();
	end
endmodule
